// [hdl/fcp_map.svh]
// constants of the flash command slice
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH
`define FCP_OP_CFG_WR    8'h11
`define FCP_OP_CFG_RD_A  8'h45
`define FCP_OP_CFG_RD_B  8'h15
`define FCP_OP_DPD       8'hb9
`define FCP_OP_REL       8'hab
`define FCP_OP_ID1       8'h90
`define FCP_OP_ID2       8'h92
`define FCP_OP_ID4       8'h94
`define FCP_ID_DEV_FIRST 8'h01
`define FCP_CFG_RST      8'h00
`define FCP_OP_BITS      6'h07
`define FCP_DATA_BITS    6'h08
`define FCP_ADDR_BITS    6'h18
`define FCP_ID4_BITS     6'h28
`define FCP_CLK_MHZ      40
`define FCP_TW_US        5000
`define FCP_TW_CYC       (`FCP_TW_US * `FCP_CLK_MHZ)
`define FCP_TDP_NS       3000
`define FCP_TDP_CYC      ((`FCP_TDP_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_RELEASE_DELAY_NS     8000
`define FCP_RELEASE_DELAY_CYC    ((`FCP_RELEASE_DELAY_NS * `FCP_CLK_MHZ + 999) / 1000)
`define FCP_RELEASE_AFTER_SIGNATURE_DELAY_NS     8000
`define FCP_RELEASE_AFTER_SIGNATURE_DELAY_CYC    ((`FCP_RELEASE_AFTER_SIGNATURE_DELAY_NS * `FCP_CLK_MHZ) / 1000)
`endif

// [hdl/fcp_pkg.sv]
// types of the flash command slice
`default_nettype none
package fcp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD  = 3'h1,
        ST_ADDR = 3'h3,
        ST_DOUT = 3'h2,
        ST_DIN  = 3'h6,
        ST_HOLD = 3'h7,
        ST_IGN  = 3'h5
    } fcp_state_t;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_CFGW = 3'h1,
        CMD_CFGR = 3'h2,
        CMD_DPD  = 3'h3,
        CMD_SIG  = 3'h4,
        CMD_ID   = 3'h5,
        CMD_ID4  = 3'h6
    } fcp_cmd_t;
endpackage : fcp_pkg
`default_nettype wire

// [hdl/fcp_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fcp_sync #(
    parameter int           W    = 1,   // number of bits
    parameter logic [W-1:0] INIT = '0   // value under reset
) (
    input  wire logic         clk,  // system clock
    input  wire logic         srst, // synchronous reset
    input  wire logic [W-1:0] d,    // asynchronous inputs
    output var  logic [W-1:0] q     // synchronised outputs
);
    genvar i;
    for (i = 0; i < W; i++)
    begin : g_bit
        logic meta_reg;
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                meta_reg <= INIT[i];
                q[i]     <= INIT[i];
            end
            else
            begin
                meta_reg <= d[i];
                q[i]     <= meta_reg;
            end
        end
    end
endmodule : fcp_sync
`default_nettype wire

// [hdl/fcp_timer.sv]
// load-and-count-down timer for self-timed cycles
`timescale 1ns/1ps
`default_nettype none
module fcp_timer (
    input  wire logic        clk,  // system clock
    input  wire logic        srst, // synchronous reset
    input  wire logic        load, // start pulse
    input  wire logic [17:0] val,  // cycles until done
    output logic             busy, // counting
    output logic             done  // pulse, val cycles after load
);
    logic [17:0] cnt_reg;
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_reg <= 18'h00000;
        else if (load)
            cnt_reg <= val;
        else if (cnt_reg != 18'h00000)
            cnt_reg <= cnt_reg - 18'h00001;
    end
    assign busy = (cnt_reg != 18'h00000);
    assign done = (cnt_reg == 18'h00001);
endmodule : fcp_timer
`default_nettype wire

// [hdl/fcp_core.sv]
// flash command slice: config register, deep power-down, id reads
`timescale 1ns/1ps
`default_nettype none
`include "fcp_map.svh"
module fcp_core #(
    parameter logic [17:0] TW_CYC    = 18'(`FCP_TW_CYC), // write cycle
    parameter logic [7:0]  MAKER_ID  = 8'h5a,  // arbitrary value
    parameter logic [7:0]  DEVICE_ID = 8'h3c   // arbitrary value
) (
    input  wire logic       CLK,      // system clock, 40 MHz
    input  wire logic       SRST,     // synchronous reset, high
    input  wire logic       CS_N,     // chip select pin, low active
    input  wire logic       SCLK,     // serial clock pin
    input  wire logic [3:0] IO_IN,    // data lines zero to three, in
    output logic      [3:0] IO_OUT,   // data lines, out
    output logic      [3:0] IO_OE_N,  // data line enables, low drives
    input  wire logic       WEL_SET,  // write enable command seen
    input  wire logic       BUSY_EXT, // program/erase/status cycle
    input  wire logic       QE,       // quad enable bit
    output logic            WRITE_IN_PROGRESS,      // write in progress
    output logic            WRITE_ENABLE_LATCH,      // write enable latch
    output logic      [7:0] CFG,      // config register
    output logic            DEEP_PD,  // deep power-down state
    output logic            STANDBY   // standby state
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    function automatic logic [7:0] shift_in(input logic [7:0] s,
        input logic [3:0] io, input logic [2:0] ln);
        case (ln)
            3'h2:    shift_in = {s[5:0], io[1:0]};
            3'h4:    shift_in = {s[3:0], io};
            default: shift_in = {s[6:0], io[0]};
        endcase
    endfunction : shift_in

    function automatic logic [15:0] rot(input logic [15:0] s,
        input logic [2:0] ln);
        case (ln)
            3'h2:    rot = {s[13:0], s[15:14]};
            3'h4:    rot = {s[11:0], s[15:12]};
            default: rot = {s[14:0], s[15]};
        endcase
    endfunction : rot

    function automatic logic [3:0] pick(input logic [15:0] s,
        input logic [2:0] ln);
        case (ln)
            3'h2:    pick = {2'h0, s[15:14]};
            3'h4:    pick = s[15:12];
            default: pick = {2'h0, s[15], 1'b0};
        endcase
    endfunction : pick

    function automatic logic [3:0] lane_mask(input logic [2:0] ln);
        case (ln)
            3'h2:    lane_mask = 4'h3;
            3'h4:    lane_mask = 4'hf;
            default: lane_mask = 4'h2;
        endcase
    endfunction : lane_mask

    function automatic logic [2:0] lanes_of(input logic [7:0] op);
        if (op == `FCP_OP_ID2)
            lanes_of = 3'h2;
        else if (op == `FCP_OP_ID4)
            lanes_of = 3'h4;
        else
            lanes_of = 3'h1;
    endfunction : lanes_of

    function automatic fcp_pkg::fcp_cmd_t dec_op(input logic [7:0] op,
        input logic bsy, input logic dpd, input logic write_enable_latch,
        input logic qe);
        dec_op = fcp_pkg::CMD_NONE;
        if (op == `FCP_OP_REL)
        begin
            if (!bsy)
                dec_op = fcp_pkg::CMD_SIG;
        end
        else if (dpd)
            dec_op = fcp_pkg::CMD_NONE;
        else if (op == `FCP_OP_CFG_RD_A || op == `FCP_OP_CFG_RD_B)
            dec_op = fcp_pkg::CMD_CFGR;
        else if (bsy)
            dec_op = fcp_pkg::CMD_NONE;
        else if (op == `FCP_OP_CFG_WR)
            dec_op = write_enable_latch ? fcp_pkg::CMD_CFGW : fcp_pkg::CMD_NONE;
        else if (op == `FCP_OP_DPD)
            dec_op = fcp_pkg::CMD_DPD;
        else if (op == `FCP_OP_ID1 || op == `FCP_OP_ID2)
            dec_op = fcp_pkg::CMD_ID;
        else if (op == `FCP_OP_ID4 && qe)
            dec_op = fcp_pkg::CMD_ID4;
    endfunction : dec_op

    fcp_pkg::fcp_state_t state_reg;
    fcp_pkg::fcp_cmd_t   cmd_reg;
    fcp_pkg::fcp_cmd_t   dec;
    logic [5:0]  sy;
    logic        cs_n_s, sclk_s, cs_d_reg, sclk_d_reg;
    logic        sclk_rise, sclk_fall, cs_rise;
    logic [3:0]  io_s;
    logic [5:0]  bit_cnt_reg, cnt_next, end_bits;
    logic [7:0]  sh_reg, sh_next, id_sel_reg, id_byte;
    logic [2:0]  lanes_reg;
    logic [15:0] out_reg;
    logic [3:0]  io_out_reg, oe_reg;
    logic        op_done, addr_done, busy, dpd_any;
    logic        wr_start, tw_done, wip_reg, wel_reg;
    logic [7:0]  cfg_reg, cfg_new_reg;
    logic        dp_start, rel_start, pwr_busy, pwr_done;
    logic        ent_reg, dpd_reg, stby_reg;
    logic [17:0] pwr_val;

    // pins into the clock domain
    fcp_sync #(
        .W    (6),
        .INIT (6'h01)
    ) u_sync (
        .clk  (CLK),
        .srst (SRST),
        .d    ({IO_IN, SCLK, CS_N}),
        .q    (sy)
    );
    assign cs_n_s = sy[0];
    assign sclk_s = sy[1];
    assign io_s   = sy[5:2];

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cs_d_reg   <= 1'b1;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            cs_d_reg   <= cs_n_s;
            sclk_d_reg <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_rise   = cs_n_s & ~cs_d_reg;

    assign busy     = wip_reg | BUSY_EXT;
    assign dpd_any  = dpd_reg | pwr_busy;
    assign sh_next  = shift_in(sh_reg, io_s, lanes_reg);
    assign cnt_next = bit_cnt_reg + {3'h0, lanes_reg};
    assign op_done  = (state_reg == fcp_pkg::ST_CMD) && sclk_rise
                      && (bit_cnt_reg == `FCP_OP_BITS);
    assign dec      = dec_op(sh_next, busy, dpd_any, wel_reg, QE);
    assign end_bits = (cmd_reg == fcp_pkg::CMD_ID4) ? `FCP_ID4_BITS
                                                     : `FCP_ADDR_BITS;
    assign addr_done = (state_reg == fcp_pkg::ST_ADDR) && sclk_rise
                       && (cnt_next == end_bits);
    assign id_byte  = (cmd_reg == fcp_pkg::CMD_ID4) ? id_sel_reg
                                                     : sh_next;

    // command sequencing
    always_ff @(posedge CLK)
    begin
        if (SRST || cs_n_s)
            state_reg <= fcp_pkg::ST_IDLE;
        else
        begin
            case (state_reg)
                fcp_pkg::ST_IDLE:
                    state_reg <= fcp_pkg::ST_CMD;
                fcp_pkg::ST_CMD:
                    if (op_done)
                    begin
                        case (dec)
                            fcp_pkg::CMD_CFGW:
                                state_reg <= fcp_pkg::ST_DIN;
                            fcp_pkg::CMD_CFGR:
                                state_reg <= fcp_pkg::ST_DOUT;
                            fcp_pkg::CMD_DPD:
                                state_reg <= fcp_pkg::ST_HOLD;
                            fcp_pkg::CMD_NONE:
                                state_reg <= fcp_pkg::ST_IGN;
                            default:
                                state_reg <= fcp_pkg::ST_ADDR;
                        endcase
                    end
                fcp_pkg::ST_ADDR:
                    if (addr_done)
                        state_reg <= fcp_pkg::ST_DOUT;
                fcp_pkg::ST_HOLD:
                    if (sclk_rise)
                        state_reg <= fcp_pkg::ST_IGN;
                default:
                    state_reg <= state_reg;
            endcase
        end
    end

    // bit capture on serial clock rise
    always_ff @(posedge CLK)
    begin
        if (SRST || cs_n_s)
        begin
            bit_cnt_reg <= 6'h00;
            sh_reg      <= 8'h00;
            lanes_reg   <= 3'h1;
            cmd_reg     <= fcp_pkg::CMD_NONE;
        end
        else if (op_done)
        begin
            bit_cnt_reg <= 6'h00;
            cmd_reg     <= dec;
            lanes_reg   <= lanes_of(sh_next);
        end
        else if (sclk_rise && state_reg != fcp_pkg::ST_DOUT
                 && state_reg != fcp_pkg::ST_IGN)
        begin
            bit_cnt_reg <= cnt_next;
            sh_reg      <= sh_next;
        end
    end

    // address byte of the id reads
    always_ff @(posedge CLK)
    begin
        if (SRST)
            id_sel_reg <= 8'h00;
        else if (state_reg == fcp_pkg::ST_ADDR && sclk_rise
                 && cnt_next == `FCP_ADDR_BITS)
            id_sel_reg <= sh_next;
    end

    // serial output on serial clock fall
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            out_reg    <= 16'h0000;
            io_out_reg <= 4'h0;
            oe_reg     <= 4'h0;
        end
        else if (cs_n_s)
            oe_reg <= 4'h0;
        else if (op_done && dec == fcp_pkg::CMD_CFGR)
            out_reg <= {cfg_reg, cfg_reg};
        else if (addr_done)
        begin
            if (cmd_reg == fcp_pkg::CMD_SIG)
                out_reg <= {DEVICE_ID, DEVICE_ID};
            else if (id_byte == `FCP_ID_DEV_FIRST)
                out_reg <= {DEVICE_ID, MAKER_ID};
            else
                out_reg <= {MAKER_ID, DEVICE_ID};
        end
        else if (state_reg == fcp_pkg::ST_DOUT && sclk_fall)
        begin
            io_out_reg <= pick(out_reg, lanes_reg);
            oe_reg     <= lane_mask(lanes_reg);
            out_reg    <= rot(out_reg, lanes_reg);
        end
    end
    assign IO_OUT  = io_out_reg;
    assign IO_OE_N = ~oe_reg;

    // config write cycle
    assign wr_start = cs_rise && (state_reg == fcp_pkg::ST_DIN)
                      && (bit_cnt_reg == `FCP_DATA_BITS);
    fcp_timer u_tw (
        .clk  (CLK),
        .srst (SRST),
        .load (wr_start),
        .val  (TW_CYC),
        .busy (),
        .done (tw_done)
    );
    always_ff @(posedge CLK)
    begin
        if (SRST)
            cfg_new_reg <= `FCP_CFG_RST;
        else if (wr_start)
            cfg_new_reg <= sh_reg;
    end
    always_ff @(posedge CLK)
    begin
        if (SRST)
            cfg_reg <= `FCP_CFG_RST;
        else if (tw_done)
            cfg_reg <= cfg_new_reg;
    end
    always_ff @(posedge CLK)
    begin
        if (SRST)
            wip_reg <= 1'b0;
        else if (wr_start)
            wip_reg <= 1'b1;
        else if (tw_done)
            wip_reg <= 1'b0;
    end
    // a new enable wins over the end-of-cycle clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
            wel_reg <= 1'b0;
        else if (WEL_SET && !dpd_any)
            wel_reg <= 1'b1;
        else if (tw_done)
            wel_reg <= 1'b0;
    end

    // power-down entry and release
    assign dp_start  = cs_rise && (state_reg == fcp_pkg::ST_HOLD);
    assign rel_start = cs_rise && dpd_reg && (cmd_reg == fcp_pkg::CMD_SIG);
    always_comb
    begin
        if (state_reg == fcp_pkg::ST_HOLD)
            pwr_val = 18'(`FCP_TDP_CYC);
        else if (state_reg == fcp_pkg::ST_ADDR && bit_cnt_reg == 6'h00)
            pwr_val = 18'(`FCP_RELEASE_DELAY_CYC);
        else
            pwr_val = 18'(`FCP_RELEASE_AFTER_SIGNATURE_DELAY_CYC);
    end
    fcp_timer u_pwr (
        .clk  (CLK),
        .srst (SRST),
        .load (dp_start | rel_start),
        .val  (pwr_val),
        .busy (pwr_busy),
        .done (pwr_done)
    );
    always_ff @(posedge CLK)
    begin
        if (SRST)
            ent_reg <= 1'b0;
        else if (dp_start)
            ent_reg <= 1'b1;
        else if (rel_start)
            ent_reg <= 1'b0;
    end
    always_ff @(posedge CLK)
    begin
        if (SRST)
            dpd_reg <= 1'b0;
        else if (pwr_done)
            dpd_reg <= ent_reg;
    end
    always_ff @(posedge CLK)
    begin
        if (SRST)
            stby_reg <= 1'b1;
        else
            stby_reg <= cs_n_s & ~busy & ~dpd_any;
    end
    assign WRITE_IN_PROGRESS     = wip_reg;
    assign WRITE_ENABLE_LATCH     = wel_reg;
    assign CFG     = cfg_reg;
    assign DEEP_PD = dpd_reg;
    assign STANDBY = stby_reg;

    property p_cfgw_wel;
        op_done && sh_next == `FCP_OP_CFG_WR && !wel_reg
        |=> state_reg == fcp_pkg::ST_IGN;
    endproperty
    a_cfgw_wel: assert property (p_cfgw_wel)
        else $error("config write taken without latch");
    property p_cfgw_bound;
        cs_rise && state_reg == fcp_pkg::ST_DIN
        && bit_cnt_reg != `FCP_DATA_BITS && !wip_reg |=> !wip_reg;
    endproperty
    a_cfgw_bound: assert property (p_cfgw_bound)
        else $error("config write started off byte boundary");
    property p_wip_cycle;
        wr_start |=> wip_reg [*8];
    endproperty
    a_wip_cycle: assert property (p_wip_cycle)
        else $error("write cycle flag dropped early");
    property p_wel_clear;
        $fell(wip_reg) |-> !wel_reg || $past(WEL_SET);
    endproperty
    a_wel_clear: assert property (p_wel_clear)
        else $error("latch not cleared at cycle end");
    property p_cfgr;
        op_done && !dpd_any && (sh_next == `FCP_OP_CFG_RD_A
        || sh_next == `FCP_OP_CFG_RD_B) |=> state_reg == fcp_pkg::ST_DOUT
        && out_reg[15:8] == $past(cfg_reg);
    endproperty
    a_cfgr: assert property (p_cfgr)
        else $error("config read not served");
    property p_dpd_ign;
        op_done && dpd_any && sh_next != `FCP_OP_REL
        |=> state_reg == fcp_pkg::ST_IGN;
    endproperty
    a_dpd_ign: assert property (p_dpd_ign)
        else $error("command decoded in power-down");
    property p_dp_entry;
        dp_start |-> ##[1:130] dpd_reg;
    endproperty
    a_dp_entry: assert property (p_dp_entry)
        else $error("power-down not reached in time");
    property p_dp_busy;
        op_done && busy && sh_next == `FCP_OP_DPD
        |=> state_reg == fcp_pkg::ST_IGN;
    endproperty
    a_dp_busy: assert property (p_dp_busy)
        else $error("power-down taken during cycle");
    property p_rel_busy;
        op_done && busy && sh_next == `FCP_OP_REL
        |=> state_reg == fcp_pkg::ST_IGN;
    endproperty
    a_rel_busy: assert property (p_rel_busy)
        else $error("release decoded during cycle");
    property p_qe;
        op_done && sh_next == `FCP_OP_ID4 && !QE
        |=> state_reg == fcp_pkg::ST_IGN;
    endproperty
    a_qe: assert property (p_qe)
        else $error("quad id read without quad enable");
    property p_id_order;
        addr_done && cmd_reg != fcp_pkg::CMD_SIG
        && id_byte == `FCP_ID_DEV_FIRST |=> out_reg[15:8] == DEVICE_ID;
    endproperty
    a_id_order: assert property (p_id_order)
        else $error("id order wrong");
    c_cfg_write: cover property (wr_start ##[1:8] wip_reg);
    c_dpd_enter: cover property ($rose(dpd_reg));
    c_quad_id: cover property (state_reg == fcp_pkg::ST_DOUT
                               && oe_reg == 4'hf);
endmodule : fcp_core
`default_nettype wire

// [sim/fcp_host_model.sv]
// serial host controller model for the flash slice
`timescale 1ns/1ps
`default_nettype none
module fcp_host_model (
    input  wire logic       clk,  // system clock
    input  wire logic [3:0] din,  // data line levels
    output var  logic       cs_n, // chip select
    output var  logic       sclk, // serial clock
    output var  logic [3:0] io    // host drive
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io   = 4'h0;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hc
    task automatic start();
        cs_n = 1'b0;
        hc(4);
    endtask : start
    // msb first, w lanes per clock
    task automatic send(input logic [39:0] d, input int n, input int w);
        for (int i = n - w; i >= 0; i -= w)
        begin
            io = d[i+:4] & ((4'h1 << w) - 4'h1);
            hc(4);
            sclk = 1'b1;
            hc(4);
            sclk = 1'b0;
        end
    endtask : send
    task automatic recv(input int n, input int w, output logic [31:0] q);
        logic [3:0] m;
        m = (4'h1 << w) - 4'h1;
        q = '0;
        for (int i = 0; i < n; i += w)
        begin
            io = ~io;
            hc(6);
            q = (q << w) | 32'((w == 1) ? {3'h0, din[1]} : (din & m));
            sclk = 1'b1;
            hc(4);
            sclk = 1'b0;
        end
    endtask : recv
    // select rises four clocks after the last serial clock fall, whole unit or not
    task automatic stop();
        hc(4);
        cs_n = 1'b1;
        io = ~io;
        hc(4);
    endtask : stop
endmodule : fcp_host_model
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the flash command slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] MK = 8'h5a; // arbitrary value
    localparam logic [7:0] DV = 8'h3c; // arbitrary value
    logic        clk;
    logic        srst;
    logic        wel_set;
    logic        busy;
    logic        qe;
    logic        cs_n;
    logic        sclk;
    logic [3:0]  hio;
    logic [3:0]  io_out;
    logic [3:0]  oe_n;
    logic [3:0]  io;
    logic        write_in_progress;
    logic        write_enable_latch;
    logic        dpd;
    logic        stb;
    logic [7:0]  cfg;
    logic [3:0]  oe_end;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    assign io = (~oe_n & io_out) | (oe_n & hio);
    fcp_core #(
        .TW_CYC    (18'd2000),
        .MAKER_ID  (MK),
        .DEVICE_ID (DV)
    ) dut (
        .CLK      (clk),
        .SRST     (srst),
        .CS_N     (cs_n),
        .SCLK     (sclk),
        .IO_IN    (io),
        .IO_OUT   (io_out),
        .IO_OE_N  (oe_n),
        .WEL_SET  (wel_set),
        .BUSY_EXT (busy),
        .QE       (qe),
        .WRITE_IN_PROGRESS      (write_in_progress),
        .WRITE_ENABLE_LATCH      (write_enable_latch),
        .CFG      (cfg),
        .DEEP_PD  (dpd),
        .STANDBY  (stb)
    );
    fcp_host_model host (
        .clk  (clk),
        .din  (io),
        .cs_n (cs_n),
        .sclk (sclk),
        .io   (hio)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic frame(input logic [7:0] op, input logic [39:0] a,
                         input int n, input int w, input int r,
                         output logic [31:0] q);
        host.start();
        host.send({32'h0, op}, 8, 1);
        host.send(a, n, w);
        host.recv(r, w, q);
        oe_end = oe_n;
        host.stop();
    endtask : frame
    task automatic wen();
        wel_set = 1'b1;
        host.hc(1);
        wel_set = 1'b0;
        host.hc(2);
    endtask : wen
    task automatic idr(input logic [7:0] op, input logic [39:0] a,
                       input int n, input int w, input logic [31:0] e);
        logic [31:0] q;
        frame(op, a, n, w, 32, q);
        chk("id_data", e, q);
    endtask : idr
    task automatic t_cfg();
        logic [31:0] q;
        int          t0;
        chk("reset", 32'h001f, {write_in_progress, write_enable_latch, cfg, dpd, stb, oe_n});
        frame(8'h11, 40'ha5, 8, 1, 0, q);
        host.hc(10);
        chk("wel_off", 32'h0, {write_in_progress, write_enable_latch});
        wen();
        frame(8'h11, 40'h52, 7, 1, 0, q);
        host.hc(10);
        chk("short", 32'h1, {write_in_progress, write_enable_latch});
        frame(8'h11, 40'ha5, 8, 1, 0, q);
        t0 = cyc;
        host.hc(6);
        chk("wip_on", 32'h6, {write_in_progress, write_enable_latch, stb});
        frame(8'h45, 40'h0, 0, 1, 16, q);
        chk("cfg_busy", 32'h0, q);
        frame(8'hb9, 40'h0, 0, 1, 0, q);
        host.hc(130);
        chk("dpd_busy", 32'h2, {write_in_progress, dpd});
        while (write_in_progress !== 1'b0 && cyc - t0 < 3000)
            host.hc(1);
        chk("tw_len", 32'h1, 32'(cyc - t0 inside {[1995:2010]}));
        chk("cfg_new", {22'h0, 8'ha5, 2'b00}, {cfg, write_enable_latch, write_in_progress});
        frame(8'h15, 40'h0, 0, 1, 16, q);
        chk("cfg_rd", 32'ha5a5, q);
        busy = 1'b1;
        frame(8'hab, 40'h0, 24, 1, 16, q);
        chk("sig_busy", 32'hf, oe_end);
        frame(8'h45, 40'h0, 0, 1, 16, q);
        chk("cfg_rd_busy", 32'ha5a5, q);
        busy = 1'b0;
    endtask : t_cfg
    task automatic t_ids();
        logic [31:0] q;
        idr(8'h90, 40'h00, 24, 1, {MK, DV, MK, DV});
        idr(8'h90, 40'h01, 24, 1, {DV, MK, DV, MK});
        idr(8'h92, 40'h01, 24, 2, {DV, MK, DV, MK});
        qe = 1'b1;
        idr(8'h94, 40'h10000, 40, 4, {DV, MK, DV, MK});
        qe = 1'b0;
        frame(8'h94, 40'h0, 40, 4, 32, q);
        chk("quad_off", 32'hf, oe_end);
        frame(8'hab, 40'h0, 24, 1, 32, q);
        host.hc(2);
        chk("sig", {DV, DV, DV, DV}, q);
        chk("sig_stb", 32'h1, stb);
    endtask : t_ids
    task automatic t_dpd();
        logic [31:0] q;
        frame(8'hb9, 40'h1, 1, 1, 0, q);
        host.hc(140);
        chk("dpd_extra", 32'h0, dpd);
        frame(8'hb9, 40'h0, 0, 1, 0, q);
        host.hc(96);
        chk("dpd_early", 32'h0, dpd);
        host.hc(34);
        chk("dpd_on", 32'h2, {dpd, stb});
        wen();
        frame(8'h11, 40'h5a, 8, 1, 0, q);
        host.hc(10);
        chk("dpd_wr", {22'h0, 8'ha5, 2'b00}, {cfg, write_enable_latch, write_in_progress});
        frame(8'h45, 40'h0, 0, 1, 16, q);
        chk("dpd_rd", 32'hf, oe_end);
        frame(8'hab, 40'h0, 0, 1, 0, q);
        host.hc(296);
        chk("rel_early", 32'h1, dpd);
        host.hc(40);
        chk("rel_done", 32'h1, {dpd, stb});
        frame(8'hb9, 40'h0, 0, 1, 0, q);
        host.hc(130);
        frame(8'hab, 40'h0, 24, 1, 16, q);
        chk("sig_dpd", {DV, DV}, q);
        host.hc(296);
        chk("rel2_early", 32'h1, dpd);
        host.hc(40);
        chk("rel2_done", 32'h0, dpd);
    endtask : t_dpd
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial
    begin
        srst = 1'b1;
        wel_set = 1'b0;
        busy = 1'b0;
        qe = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        host.hc(4);
        t_cfg();
        t_ids();
        t_dpd();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
